// ### fbod_pkg.sv
`default_nettype none
package fbod_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    // Bus timing figures in ns and derived clock cycle counts
    localparam int CLK_PERIOD_NS = 5;
    localparam int ACCESS_NS = 120;
    localparam int WRITE_PULSE_NS = 50;
    localparam int RESET_PULSE_NS = 500;
    localparam int RECOVERY_NS = 50;
    localparam int READY_BUSY_NS = 20000;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_CYC = READY_BUSY_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    typedef enum logic [2:0] {
        FBOD_IDLE  = 3'b000,
        FBOD_READ  = 3'b001,
        FBOD_WRITE = 3'b011,
        FBOD_RST   = 3'b010,
        FBOD_RWAIT = 3'b110,
        FBOD_RECOV = 3'b111,
        FBOD_GAP   = 3'b101
    } fbod_state_type;
endpackage
`default_nettype wire

// ### fbod_timer.sv
`default_nettype none
module fbod_timer #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    logic [W-1:0] cnt_q;
    assign done = (cnt_q == '0);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (load) begin
                cnt_q <= value;
            end else if (!done) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### fbod_host.sv
`default_nettype none
// Summary of operation
// - Read: select and output enable low
// - Write: select, write enable low, OE high
// - Allow select access time after standby
// - Reset request takes priority over read and write
// - Wait recovery time before reading
module fbod_host
    import fbod_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_CYC,
    parameter int READY_CYCLES = READY_CYC
) (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       clk_en,
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic [fbod_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [fbod_pkg::DATA_W-1:0] req_wdata,
    input  wire logic                       req_reset,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic [fbod_pkg::DATA_W-1:0]     rsp_rdata,
    output logic                            dev_busy,
    output logic [fbod_pkg::ADDR_W-1:0]     address_pins,
    output logic [fbod_pkg::DATA_W-1:0]     data_pins_o,
    output logic                            data_pins_oe,
    input  wire logic [fbod_pkg::DATA_W-1:0] data_pins_i,
    output logic                            chip_sel_n,
    output logic                            out_en_n,
    output logic                            wr_en_n,
    output logic                            reset_n,
    input  wire logic                       ready_busy_n
);
    import fbod_pkg::*;

    // ******************************
    // Sequencer state
    // ******************************
    fbod_state_type    st_q, st_d;
    logic              tmr_load;
    logic [CNT_W-1:0]  tmr_val;
    logic              tmr_done;
    logic              start_rd, start_wr, start_rst;
    logic              boot_q;

    assign start_rst = (st_q == FBOD_IDLE) && (req_reset || boot_q);
    assign start_rd  = (st_q == FBOD_IDLE) && req_valid && !req_write && !req_reset;
    assign start_wr  = (st_q == FBOD_IDLE) && req_valid && req_write && !req_reset;

    fbod_timer #(.W(CNT_W)) u_timer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .load     (tmr_load),
        .value    (tmr_val),
        .done     (tmr_done)
    );

    always_comb begin
        st_d     = st_q;
        tmr_load = 1'b0;
        tmr_val  = '0;
        case (st_q)
            FBOD_IDLE: begin
                if (start_rst) begin
                    st_d = FBOD_RST;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(RESET_CYCLES);
                end else if (start_rd) begin
                    st_d = FBOD_READ;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(ACCESS_CYC);
                end else if (start_wr) begin
                    st_d = FBOD_WRITE;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(WRITE_CYC);
                end
            end
            FBOD_READ:  if (tmr_done) st_d = FBOD_GAP;
            FBOD_WRITE: if (tmr_done) st_d = FBOD_GAP;
            FBOD_GAP:   st_d = FBOD_IDLE;
            FBOD_RST: begin
                if (tmr_done) begin
                    st_d = FBOD_RWAIT;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(READY_CYCLES);
                end
            end
            FBOD_RWAIT: begin
                if (tmr_done || ready_busy_n) begin
                    st_d = FBOD_RECOV;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(RECOVERY_CYC);
                end
            end
            FBOD_RECOV: if (tmr_done) st_d = FBOD_IDLE;
            default:    st_d = FBOD_IDLE;
        endcase
    end

    // ******************************
    // Pin drive
    // ******************************
    wire rd_d  = (st_d == FBOD_READ);
    wire wr_d  = (st_d == FBOD_WRITE);
    wire rst_d = (st_d == FBOD_RST);
    wire sel_d = (rd_d || wr_d) && !rst_d;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q          <= FBOD_IDLE;
            chip_sel_n    <= 1'b1;
            out_en_n      <= 1'b1;
            wr_en_n       <= 1'b1;
            reset_n       <= 1'b0;
            data_pins_oe  <= 1'b0;
            data_pins_o   <= '0;
            address_pins  <= '0;
            req_ready     <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_rdata     <= '0;
            dev_busy      <= 1'b0;
            boot_q        <= 1'b1;
        end else if (clk_en) begin
            st_q         <= st_d;
            chip_sel_n   <= !sel_d;
            out_en_n     <= !rd_d;
            wr_en_n      <= !wr_d;
            reset_n      <= !rst_d;
            data_pins_oe <= wr_d;
            req_ready    <= (st_d == FBOD_IDLE);
            dev_busy     <= !ready_busy_n;
            if (start_rst) begin
                boot_q <= 1'b0;
            end
            rsp_valid    <= (st_q == FBOD_READ) && tmr_done;
            if (start_rd || start_wr) begin
                address_pins <= req_addr;
                data_pins_o  <= req_wdata;
            end
            if ((st_q == FBOD_READ) && tmr_done) begin
                rsp_rdata <= data_pins_i;
            end
        end
    end

    // ******************************
    // Checks
    // ******************************
    a_read_no_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        !out_en_n |-> wr_en_n && !chip_sel_n && !data_pins_oe)
        else $error("read cycle with write enable or bus drive");
    a_write_oe_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        !wr_en_n |-> out_en_n && !chip_sel_n && data_pins_oe)
        else $error("write cycle with output enable low");
    a_reset_priority: assert property (@(posedge core_clk) disable iff (sys_rst)
        !reset_n |-> chip_sel_n && out_en_n && wr_en_n)
        else $error("control pins active during reset");
    a_reset_width: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(reset_n) |-> !reset_n [*8])
        else $error("reset pulse too short");
    a_read_access: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(out_en_n) |-> !out_en_n [*8])
        else $error("read strobe shorter than access time");
    a_recovery_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(reset_n) |-> out_en_n [*8])
        else $error("read started inside recovery time");

    // ******************************
    // Pin timing monitors
    // ******************************
    logic [CNT_W-1:0]  acc_cnt_q, acc_cnt_d;
    logic [CNT_W-1:0]  rst_cnt_q, rst_cnt_d;
    logic [CNT_W-1:0]  rec_cnt_q, rec_cnt_d;

    // Saturating counts of enabled cycles per pin level
    assign acc_cnt_d = (chip_sel_n || out_en_n) ? '0 : acc_cnt_q + CNT_W'(!(&acc_cnt_q));
    assign rst_cnt_d = reset_n ? '0 : rst_cnt_q + CNT_W'(!(&rst_cnt_q));
    assign rec_cnt_d = !reset_n ? '0 : rec_cnt_q + CNT_W'(!(&rec_cnt_q));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acc_cnt_q <= '0;
            rst_cnt_q <= '0;
            rec_cnt_q <= '0;
        end else if (clk_en) begin
            acc_cnt_q <= acc_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            rec_cnt_q <= rec_cnt_d;
        end
    end

    // ******************************
    // Timing checks
    // ******************************
    a_access_time: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && (st_q == FBOD_READ) && tmr_done |-> acc_cnt_q >= CNT_W'(ACCESS_CYC))
        else $error("read data taken before access time");
    a_reset_long: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(reset_n) |-> rst_cnt_q > CNT_W'(RESET_CYCLES))
        else $error("reset pulse shorter than its count");
    a_recovery_time: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(out_en_n) |-> rec_cnt_q > CNT_W'(RECOVERY_CYC))
        else $error("read strobe inside reset recovery");
    a_standby_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        req_ready |-> chip_sel_n && out_en_n && wr_en_n)
        else $error("device selected while idle");
endmodule
`default_nettype wire

// ### fbod_flash_model.sv
`default_nettype none
module fbod_flash_model
    import fbod_pkg::*;
#(
    parameter int BUSY_CYC = 200
) (
    input  wire logic                        core_clk,
    input  wire logic [fbod_pkg::ADDR_W-1:0] address_pins,
    input  wire logic [fbod_pkg::DATA_W-1:0] host_data,
    input  wire logic                        host_oe,
    input  wire logic                        chip_sel_n,
    input  wire logic                        out_en_n,
    input  wire logic                        wr_en_n,
    input  wire logic                        reset_n,
    output logic [fbod_pkg::DATA_W-1:0]      data_pins,
    output logic                             ready_busy_n,
    output logic [fbod_pkg::DATA_W-1:0]      cmd_data_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Array, status and pin drive
    // ****************************************
    int                        busy_q = 0;
    logic [fbod_pkg::DATA_W-1:0] last_q = 8'h00;
    logic [fbod_pkg::DATA_W-1:0] dev_d;
    logic                        dev_oe;
    assign dev_d = (busy_q > 0) ? 8'h80 : address_pins[7:0] ^ address_pins[15:8]
                   ^ {4'h0, address_pins[19:16]};
    assign dev_oe = reset_n && !chip_sel_n && !out_en_n;
    assign data_pins = host_oe ? host_data : (dev_oe ? dev_d : ~last_q);
    assign ready_busy_n = (busy_q == 0);
    always @(posedge core_clk) begin
        last_q <= data_pins;
        if (!reset_n) begin
            busy_q <= 0;
        end else if (!chip_sel_n && !wr_en_n && out_en_n) begin
            cmd_data_q <= host_data;
            busy_q <= BUSY_CYC;
        end else if (busy_q > 0) begin
            busy_q <= busy_q - 1;
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fbod_pkg::*;
    localparam int RST_C = 8;
    logic        core_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, req_reset = 0;
    logic [19:0] req_addr = 20'h00000, address_pins;
    logic [7:0]  req_wdata = 8'h00, rsp_rdata, data_pins_o, data_pins_i, cmd_data;
    logic        req_ready, rsp_valid, dev_busy, data_pins_oe, ready_busy_n;
    logic        chip_sel_n, out_en_n, wr_en_n, reset_n;
    logic        clk_en = 1;
    int          err_total = 0, compares = 0, seed = 32'hcc1f, n, lo;
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        clk_en = ($random(seed) & 3) != 0;
    end
    fbod_host #(.RESET_CYCLES(RST_C), .READY_CYCLES(20)) i_dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_reset(req_reset),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .dev_busy(dev_busy), .address_pins(address_pins), .data_pins_o(data_pins_o),
        .data_pins_oe(data_pins_oe), .data_pins_i(data_pins_i), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .wr_en_n(wr_en_n), .reset_n(reset_n),
        .ready_busy_n(ready_busy_n));
    fbod_flash_model i_dev (.core_clk(core_clk), .address_pins(address_pins),
        .host_data(data_pins_o), .host_oe(data_pins_oe), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .wr_en_n(wr_en_n), .reset_n(reset_n),
        .data_pins(data_pins_i), .ready_busy_n(ready_busy_n), .cmd_data_q(cmd_data));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_ready();
        lo = 0;
        for (n = 0; n < 3000 && req_ready !== 1'b1; n++) begin
            if (reset_n === 1'b0) lo++;
            @(negedge core_clk);
        end
        if (n == 3000) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic hold_req();
        for (n = 0; n < 100 && req_ready !== 1'b0; n++) @(negedge core_clk);
        if (n == 100) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic do_read(input logic [19:0] a, input logic [7:0] exp);
        wait_ready();
        req_addr = a;
        req_write = 0;
        req_valid = 1;
        hold_req();
        req_valid = 0;
        for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(negedge core_clk);
        if (n == 100) begin
            err_total++;
            tally_and_finish();
        end
        check("read data", exp, rsp_rdata);
    endtask
    task automatic do_write(input logic [19:0] a, input logic [7:0] d);
        wait_ready();
        req_addr = a;
        req_wdata = d;
        req_write = 1;
        req_valid = 1;
        hold_req();
        req_valid = 0;
        wait_ready();
        check("command latch", d, cmd_data);
    endtask
    task automatic do_reset();
        wait_ready();
        req_reset = 1;
        hold_req();
        req_reset = 0;
        wait_ready();
        check("reset width", 8'h01, {7'h00, lo >= RST_C});
        check("busy after reset", 8'h00, {7'h00, dev_busy});
    endtask
    function automatic logic [7:0] arr(input logic [19:0] a);
        return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
    endfunction
    function automatic logic [19:0] rnd();
        return 20'($random(seed));
    endfunction
    // ****************************************
    // Main sequence
    // ****************************************
    logic [19:0] a;
    initial begin
        repeat (3) @(negedge core_clk);
        sys_rst = 0;
        for (int i = 0; i < 6; i++) begin
            a = rnd();
            do_read(a, arr(a));
        end
        $display("read test done");
        do_write(rnd(), 8'($random(seed)));
        check("busy after write", 8'h01, {7'h00, dev_busy});
        do_read(rnd(), 8'h80);
        $display("write test done");
        do_reset();
        a = rnd();
        do_read(a, arr(a));
        do_reset();
        a = rnd();
        do_read(a, arr(a));
        do_write(rnd(), 8'($random(seed)));
        $display("reset test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
